//--- inc/ucode_store_pkg.sv
// Purpose: shared constants and types for the writable microcode store
// Assumes: single processor clock, synchronous active-high reset
// Notes: the load port target field selects one of the writable stores
package ucode_store_pkg;
	localparam int WORD_W = 64;
	localparam int PAGE_WORDS = 512;
	localparam int PAGE_AW = 9;
	localparam int MAX_PAGES = 4;
	localparam int CS_AW = 11;
	localparam int STACK_DEPTH = 16;
	localparam int STACK_PW = 5;
	localparam int DEC_WORDS = 16;
	localparam int DEC_W = 16;
	localparam int IO_WORDS = 256;
	localparam int IO_AW = 8;
	localparam int IO_W = 16;
	// microword field positions
	localparam int NEXT_LSB = 0;
	localparam int NEXT_W = 11;
	localparam int COND_LSB = 11;
	localparam int COND_W = 4;
	localparam int MEMOP_LSB = 15;
	localparam int MEMOP_W = 2;
	localparam int ALUFN_LSB = 17;
	localparam int ALUFN_W = 7;
	localparam logic [63:0] CB_RESET = 64'h0000000000000000;

	typedef enum logic [1:0] {
		ST_NONE,
		ST_PUSH,
		ST_POP,
		ST_DELETE
	} stack_op_t;

	typedef enum logic [1:0] {
		LD_CENTRAL,
		LD_DECODER,
		LD_IO
	} load_target_t;

	typedef struct packed {
		logic [NEXT_W-1:0] next_addr;
		logic [COND_W-1:0] branch_cond;
		logic [MEMOP_W-1:0] mem_op;
		logic [ALUFN_W-1:0] alu_fn;
	} uword_fields_t;

	typedef struct packed {
		logic valid;
		load_target_t target;
		logic [CS_AW-1:0] addr;
		logic [WORD_W-1:0] data;
	} load_req_t;
endpackage : ucode_store_pkg

//--- core/subroutine_stack.sv
// Purpose: lifo return stack for microcode subroutine call and return
// Assumes: one operation per clock
// Notes: overflow and underflow leave contents unchanged
`timescale 1ns/1ps
module subroutine_stack
	import ucode_store_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int AW = CS_AW
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// operation
	input wire stack_op_t op,
	input wire logic [AW-1:0] push_addr,
	// result
	output logic [AW-1:0] top_addr,
	output logic [STACK_PW-1:0] count,
	output logic error
);
	logic [AW-1:0] mem [DEPTH];
	logic [STACK_PW-1:0] count_reg;
	logic [AW-1:0] top_reg;
	logic error_reg;
	logic full;
	logic empty;
	logic [STACK_PW-2:0] top_index;

	assign full = (count_reg == STACK_PW'(DEPTH));
	assign top_index = count_reg[STACK_PW-2:0] - 1'b1;
	assign empty = (count_reg == '0);

	// ====================================================
	// storage
	always_ff @(posedge clk)
	begin
		if (op == ST_PUSH && !full)
		begin
			mem[count_reg[STACK_PW-2:0]] <= push_addr;
		end
	end

	// ====================================================
	// pointer and error
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			count_reg <= '0;
			error_reg <= 1'b0;
		end
		else
		begin
			error_reg <= 1'b0;
			case (op)
				ST_PUSH:
					if (full)
						error_reg <= 1'b1;
					else
						count_reg <= count_reg + 1'b1;
				ST_POP, ST_DELETE:
					if (empty)
						error_reg <= 1'b1;
					else
						count_reg <= count_reg - 1'b1;
				default:
					count_reg <= count_reg;
			endcase
		end
	end

	// last popped entry, registered
	always_ff @(posedge clk)
	begin
		if (reset)
			top_reg <= '0;
		else if (op == ST_POP && !empty)
			top_reg <= mem[top_index];
	end

	assign top_addr = top_reg;
	assign count = count_reg;
	assign error = error_reg;
endmodule : subroutine_stack

//--- core/writable_microcode_store.sv
// Purpose: writable control, decoder and i/o stores with return stack
// Assumes: processor clock only; loads arrive from the i/o path
// Notes: page zero is read-only and supplied from outside
//
// Behaviour
// - Each clock delivers one complete 64-bit microword to the buffer.
// - Each writable unit is a full 512-word page or a half page.
// - The return stack holds at most 16 addresses.
// - The stack supports push, pop and delete of an entry.
// - The decoder store is two 16x16 arrays that map an instruction.
// - The i/o control store is 256 words of 16 bits.
// - Writable stores load from memory via i/o writes; page zero is fixed.
// - Up to three writable pages give 2048 words with page zero.
// - The microword has next address, test, memory op and alu fields.
// - The control buffer loads from the 64-bit central store, or a cleared word for unfitted addresses.
// - The central store is 512x64 pages with page zero read-only.
`timescale 1ns/1ps
module writable_microcode_store
	import ucode_store_pkg::*;
#(
	parameter int PAGES_FITTED = 3,
	parameter bit HALF_PAGE = 1'b0,
	parameter bit HAS_DECODER = 1'b1,
	parameter bit HAS_IO_STORE = 1'b1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// sequencer
	input wire logic [CS_AW-1:0] next_addr,
	input wire logic [WORD_W-1:0] rom_word,
	output logic [WORD_W-1:0] control_buffer,
	output uword_fields_t fields,
	// subroutine stack
	input wire stack_op_t stack_op,
	input wire logic [CS_AW-1:0] stack_push_addr,
	output logic [CS_AW-1:0] stack_top,
	output logic [STACK_PW-1:0] stack_count,
	output logic stack_error,
	// instruction decode
	input wire logic [DEC_W-1:0] instr,
	output logic [CS_AW-1:0] decode_addr,
	// i/o control store read
	input wire logic [IO_AW-1:0] io_addr,
	output logic [IO_W-1:0] io_word,
	// load port
	input wire load_req_t load,
	output logic load_reject
);
	localparam int WPAGES = MAX_PAGES - 1;
	localparam int PAGE_USED = HALF_PAGE ? PAGE_WORDS / 2 : PAGE_WORDS;
	localparam int UNIT_AW = $clog2(PAGE_USED);

	// side store arrays
	logic [DEC_W-1:0] dec_hi [DEC_WORDS];
	logic [DEC_W-1:0] dec_lo [DEC_WORDS];
	logic [IO_W-1:0] io_mem [IO_WORDS];
	// words offered by the writable page units
	logic [WORD_W-1:0] page_word [WPAGES];
	// registered outputs
	logic [WORD_W-1:0] cb_reg;
	logic [CS_AW-1:0] dec_reg;
	logic [IO_W-1:0] io_reg;
	logic reject_reg;
	// address split
	logic [1:0] rd_page;
	logic [1:0] rd_unit;
	logic rd_fitted;
	logic [1:0] ld_page;
	logic [PAGE_AW-1:0] ld_off;
	logic ld_ok;

	assign rd_page = next_addr[CS_AW-1:PAGE_AW];
	assign rd_unit = rd_page - 2'h1;
	assign rd_fitted = 32'(rd_page) <= PAGES_FITTED
		&& 32'(next_addr[PAGE_AW-1:0]) < PAGE_USED;
	assign ld_page = load.addr[CS_AW-1:PAGE_AW];
	assign ld_off = load.addr[PAGE_AW-1:0];

	// ====================================================
	// writable pages, one unit per fitted page
	for (genvar p = 0; p < WPAGES; p++)
	begin : g_page
		if (p < PAGES_FITTED)
		begin : g_fitted
			logic [WORD_W-1:0] unit_mem [PAGE_USED];
			logic [UNIT_AW-1:0] unit_rd;
			logic unit_we;

			assign unit_rd = next_addr[UNIT_AW-1:0];
			assign unit_we = load.valid && ld_ok
				&& load.target == LD_CENTRAL
				&& 32'(ld_page) == p + 1;

			always_ff @(posedge clk)
			begin
				if (unit_we)
					unit_mem[ld_off[UNIT_AW-1:0]] <= load.data;
			end
			assign page_word[p] = unit_mem[unit_rd];
		end
		else
		begin : g_absent
			// an empty slot reads as a cleared word
			assign page_word[p] = CB_RESET;
		end
	end

	// ====================================================
	// load acceptance
	// page zero and unfitted pages refuse loads
	always_comb
	begin
		ld_ok = 1'b0;
		case (load.target)
			LD_CENTRAL:
				ld_ok = ld_page != 2'h0
					&& 32'(ld_page) <= PAGES_FITTED
					&& 32'(ld_off) < PAGE_USED;
			LD_DECODER:
				ld_ok = HAS_DECODER;
			LD_IO:
				ld_ok = HAS_IO_STORE;
			default:
				ld_ok = 1'b0;
		endcase
	end

	// ====================================================
	// store writes
	always_ff @(posedge clk)
	begin
		if (load.valid && ld_ok)
		begin
			case (load.target)
				LD_DECODER:
				begin
					if (load.addr[4])
						dec_hi[load.addr[3:0]] <= load.data[DEC_W-1:0];
					else
						dec_lo[load.addr[3:0]] <= load.data[DEC_W-1:0];
				end
				LD_IO:
					io_mem[load.addr[IO_AW-1:0]] <= load.data[IO_W-1:0];
				default:
				begin
					// central words are written by the page units
				end
			endcase
		end
	end

	// ====================================================
	// load refusal flag
	always_ff @(posedge clk)
	begin
		if (reset)
			reject_reg <= 1'b0;
		else
			reject_reg <= load.valid && !ld_ok;
	end

	// ====================================================
	// control buffer
	always_ff @(posedge clk)
	begin
		if (reset)
			cb_reg <= CB_RESET;
		else if (rd_page == 2'h0)
			cb_reg <= rom_word;
		else if (rd_fitted)
			cb_reg <= page_word[rd_unit];
		else
			cb_reg <= CB_RESET;
	end

	assign control_buffer = cb_reg;
	assign fields.next_addr = cb_reg[NEXT_LSB +: NEXT_W];
	assign fields.branch_cond = cb_reg[COND_LSB +: COND_W];
	assign fields.mem_op = cb_reg[MEMOP_LSB +: MEMOP_W];
	assign fields.alu_fn = cb_reg[ALUFN_LSB +: ALUFN_W];

	// ====================================================
	// decoder: opcode nibble picks hi entry, next nibble lo entry
	always_ff @(posedge clk)
	begin
		if (reset || !HAS_DECODER)
			dec_reg <= '0;
		else
			dec_reg <= CS_AW'(dec_hi[instr[15:12]])
				| CS_AW'(dec_lo[instr[11:8]]);
	end
	assign decode_addr = dec_reg;

	// ====================================================
	// i/o control store
	always_ff @(posedge clk)
	begin
		if (reset || !HAS_IO_STORE)
			io_reg <= '0;
		else
			io_reg <= io_mem[io_addr];
	end
	assign io_word = io_reg;
	assign load_reject = reject_reg;

	// ====================================================
	// return stack
	// overflow and underflow are refused inside the stack
	subroutine_stack #(
		.DEPTH(STACK_DEPTH),
		.AW(CS_AW)
	) u_stack (
		.clk(clk),
		.reset(reset),
		.op(stack_op),
		.push_addr(stack_push_addr),
		.top_addr(stack_top),
		.count(stack_count),
		.error(stack_error)
	);
endmodule : writable_microcode_store

//--- test/page_zero_rom.sv
// Purpose: fixed page-zero microcode model beside the store
// Assumes: combinational read of the sequencer address
// Notes: other pages see an inverted pattern the store must ignore
`timescale 1ns/1ps
module page_zero_rom
	import ucode_store_pkg::*;
(
	// sequencer address
	input wire logic [CS_AW-1:0] next_addr,
	// fixed microword
	output logic [WORD_W-1:0] rom_word
);
	assign rom_word = (next_addr[10:9] == 2'h0) ?
		{4{5'h00, next_addr}} : ~{4{5'h00, next_addr}};
endmodule : page_zero_rom

//--- test/ucode_store_props.sv
// Purpose: port assertions for the writable microcode store
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module ucode_store_props
	import ucode_store_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// watched ports
	input wire logic [CS_AW-1:0] next_addr,
	input wire logic [WORD_W-1:0] rom_word,
	input wire logic [WORD_W-1:0] control_buffer,
	input wire uword_fields_t fields,
	input wire stack_op_t stack_op,
	input wire logic [CS_AW-1:0] stack_push_addr,
	input wire logic [CS_AW-1:0] stack_top,
	input wire logic [STACK_PW-1:0] stack_count,
	input wire logic stack_error,
	input wire load_req_t load,
	input wire logic load_reject
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ==========
	// assertions
	a_rom_page_load: assert property (
		next_addr[10:9] == 2'h0 |=> control_buffer == $past(rom_word))
		else $error("page zero word not loaded");
	a_field_slices: assert property (
		fields.next_addr == control_buffer[10:0] &&
		fields.branch_cond == control_buffer[14:11] &&
		fields.mem_op == control_buffer[16:15] &&
		fields.alu_fn == control_buffer[23:17])
		else $error("microword fields misplaced");
	a_stack_depth: assert property (stack_count <= 5'h10)
		else $error("stack count above depth");
	a_push_counts: assert property (
		stack_op == ST_PUSH && stack_count < 5'h10 |=>
		stack_count == $past(stack_count) + 5'h01 && !stack_error)
		else $error("push did not count");
	a_full_push: assert property (
		stack_op == ST_PUSH && stack_count == 5'h10 |=>
		stack_error && stack_count == 5'h10)
		else $error("overflow not refused");
	a_empty_pop: assert property (
		stack_op inside {ST_POP, ST_DELETE} && stack_count == 5'h00
		|=> stack_error && stack_count == 5'h00)
		else $error("underflow not refused");
	a_lifo_return: assert property (
		stack_op == ST_PUSH && stack_count < 5'h10 ##1 stack_op == ST_POP
		|=> stack_top == $past(stack_push_addr, 2))
		else $error("pop did not return last push");
	a_page0_locked: assert property (
		load.valid && load.target == LD_CENTRAL && load.addr[10:9] == 2'h0
		|=> load_reject)
		else $error("page zero load accepted");
	c_full: cover property (stack_count == 5'h10 && stack_op == ST_PUSH);
	c_reject: cover property (load_reject);
	c_empty_pop: cover property (stack_error && stack_count == 5'h00);
endmodule : ucode_store_props

//--- test/writable_microcode_store_bench.sv
// Purpose: directed bench for the writable microcode store
// Assumes: DUT at default parameters with three pages fitted; DUT_HALF with one half page
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module writable_microcode_store_bench
	import ucode_store_pkg::*;
;
	logic clk, reset, stack_error, load_reject;
	logic [CS_AW-1:0] next_addr, stack_push_addr, stack_top, decode_addr;
	logic [WORD_W-1:0] rom_word, control_buffer;
	logic [STACK_PW-1:0] stack_count;
	logic [DEC_W-1:0] instr;
	logic [IO_AW-1:0] io_addr;
	logic [IO_W-1:0] io_word, half_io;
	logic [WORD_W-1:0] half_buffer;
	logic [CS_AW-1:0] half_decode;
	logic half_reject;
	uword_fields_t fields;
	stack_op_t stack_op;
	load_req_t load;
	int num_errors = 0;
	int samples_checked = 0;
	page_zero_rom rom (.next_addr, .rom_word);
	writable_microcode_store DUT (.clk, .reset, .next_addr, .rom_word,
		.control_buffer, .fields, .stack_op, .stack_push_addr, .stack_top,
		.stack_count, .stack_error, .instr, .decode_addr, .io_addr,
		.io_word, .load, .load_reject);
	writable_microcode_store #(.PAGES_FITTED(1), .HALF_PAGE(1'b1),
		.HAS_DECODER(1'b0), .HAS_IO_STORE(1'b0)) DUT_HALF (.clk, .reset,
		.next_addr, .rom_word, .control_buffer(half_buffer), .fields(),
		.stack_op, .stack_push_addr, .stack_top(), .stack_count(),
		.stack_error(), .instr, .decode_addr(half_decode), .io_addr,
		.io_word(half_io), .load, .load_reject(half_reject));
	// ==========
	// shared tasks
	task chk(input string what, input logic [63:0] exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task ld(input load_target_t t, input logic [10:0] a, d);
		load = '{1'b1, t, a, 64'(d)};
		@(negedge clk);
	endtask : ld
	task sop(input stack_op_t o, input logic [10:0] a);
		stack_op = o;
		stack_push_addr = a;
		@(negedge clk);
	endtask : sop
	task end_sim;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// ==========
	// scenarios
	task t_central;
		load = '{1'b1, LD_CENTRAL, 11'h200, 64'h0123456789abcdef};
		@(negedge clk);
		load = '{1'b1, LD_CENTRAL, 11'h7ff, 64'hfedcba9876543210};
		@(negedge clk);
		ld(LD_CENTRAL, 11'h005, 11'h000);
		load.valid = 1'b0;
		chk("reject", 64'h1, 64'(load_reject));
		next_addr = 11'h200;
		@(negedge clk);
		chk("page one", 64'h0123456789abcdef, control_buffer);
		next_addr = 11'h7ff;
		@(negedge clk);
		chk("top page", 64'hfedcba9876543210, control_buffer);
		chk("alu field", 64'h2a, 64'(fields.alu_fn));
		next_addr = 11'h005;
		@(negedge clk);
		chk("page zero", {4{16'h0005}}, control_buffer);
	endtask : t_central
	task t_stack;
		for (int i = 0; i < 17; i++)
			sop(ST_PUSH, 11'(11'h100 + i));
		chk("full error", 64'h1, 64'(stack_error));
		chk("full count", 64'h10, 64'(stack_count));
		for (int i = 15; i >= 0; i--)
		begin
			sop(ST_POP, 11'h000);
			chk("pop", 64'(11'h100 + i), 64'(stack_top));
		end
		sop(ST_POP, 11'h000);
		chk("empty error", 64'h1, 64'(stack_error));
		sop(ST_PUSH, 11'h3c5);
		sop(ST_DELETE, 11'h000);
		chk("delete", 64'h0, 64'(stack_count));
		sop(ST_PUSH, 11'h07a);
		sop(ST_POP, 11'h000);
		stack_op = ST_NONE;
		chk("push pop", 64'h07a, 64'(stack_top));
	endtask : t_stack
	task t_side_stores;
		ld(LD_DECODER, 11'h013, 11'h100);
		ld(LD_DECODER, 11'h005, 11'h005);
		ld(LD_IO, 11'h0ff, 11'h5a3);
		load.valid = 1'b0;
		instr = 16'h3500;
		io_addr = 8'hff;
		@(negedge clk);
		chk("decode", 64'h105, 64'(decode_addr));
		chk("io word", 64'h5a3, 64'(io_word));
	endtask : t_side_stores
	task t_half;
		ld(LD_CENTRAL, 11'h200, 11'h3a5);
		chk("half accept", 64'h0, 64'(half_reject));
		ld(LD_CENTRAL, 11'h300, 11'h001);
		chk("half offset", 64'h1, 64'(half_reject));
		ld(LD_CENTRAL, 11'h400, 11'h002);
		chk("unfitted page", 64'h1, 64'(half_reject));
		ld(LD_IO, 11'h010, 11'h003);
		chk("no io store", 64'h1, 64'(half_reject));
		ld(LD_DECODER, 11'h010, 11'h004);
		load.valid = 1'b0;
		chk("no decoder", 64'h1, 64'(half_reject));
		next_addr = 11'h200;
		@(negedge clk);
		chk("half word", 64'h3a5, half_buffer);
		chk("no decode", 64'h0, 64'(half_decode));
		chk("no io", 64'h0, 64'(half_io));
		next_addr = 11'h300;
		@(negedge clk);
		chk("half hole", CB_RESET, half_buffer);
	endtask : t_half
	// ==========
	// clock, reset, run
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		reset = 1'b1;
		next_addr = '0;
		stack_op = ST_NONE;
		stack_push_addr = '0;
		instr = '0;
		io_addr = '0;
		load = '0;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		t_central();
		t_stack();
		t_side_stores();
		t_half();
		end_sim();
	end
	initial
	begin
		repeat (1000) @(posedge clk);
		num_errors++;
		end_sim();
	end
endmodule : writable_microcode_store_bench
bind writable_microcode_store ucode_store_props props (.clk, .reset,
	.next_addr, .rom_word, .control_buffer, .fields, .stack_op,
	.stack_push_addr, .stack_top, .stack_count, .stack_error, .load,
	.load_reject);
